//--- pkg/obcu_pkg.sv
/*
 obcu_pkg: opcodes, reset values, timing constants and carrier structs
 for the one-bit control unit core and its AXI4-Lite register slave.
 assumes a 100 MHz aclk.
*/
package obcu_pkg;

   // opcode encodings
   typedef enum logic [3:0] {
      OP_IDLE_A = 4'h0,
      OP_LOAD = 4'h1,
      OP_LOAD_INV = 4'h2,
      OP_AND = 4'h3,
      OP_AND_INV = 4'h4,
      OP_OR = 4'h5,
      OP_OR_INV = 4'h6,
      OP_XNOR = 4'h7,
      OP_WRITE = 4'h8,
      OP_WRITE_INV = 4'h9,
      OP_IN_EN = 4'ha,
      OP_OUT_EN = 4'hb,
      OP_JUMP = 4'hc,
      OP_RETURN = 4'hd,
      OP_SKIP_ZERO = 4'he,
      OP_IDLE_B = 4'hf
   } obcu_op_t;

   localparam int OBCU_OP_W = 4;
   localparam int OBCU_OP_MSB = 3;

   // reset values
   localparam logic OBCU_RESULT_RST = 1'b0;
   localparam logic OBCU_IN_EN_RST = 1'b0;
   localparam logic OBCU_OUT_EN_RST = 1'b0;

   // reset-to-clock-out response: half a period, at least one cycle
   localparam int OBCU_CLK_PERIOD_NS = 10;
   localparam int OBCU_RST_RESP_NS = OBCU_CLK_PERIOD_NS / 2;
   localparam int OBCU_RST_RESP_CYC_RAW =
      (OBCU_RST_RESP_NS * 100) / 1000;
   localparam int OBCU_RST_RESP_CYC =
      (OBCU_RST_RESP_CYC_RAW < 1) ? 1 : OBCU_RST_RESP_CYC_RAW;

   // register byte offsets
   localparam logic [3:0] OBCU_REG_STATUS = 4'h0;
   localparam logic [3:0] OBCU_REG_CTRL = 4'h4;
   localparam logic [3:0] OBCU_REG_COUNT = 4'h8;

   // status and control field positions
   localparam int OBCU_ST_RESULT = 0;
   localparam int OBCU_ST_IN_EN = 1;
   localparam int OBCU_ST_OUT_EN = 2;
   localparam int OBCU_ST_SKIP = 3;
   localparam int OBCU_CTRL_RUN = 0;
   localparam logic OBCU_RUN_RST = 1'b1;

   localparam logic [1:0] OBCU_RESP_OKAY = 2'h0;
   localparam logic [1:0] OBCU_RESP_SLVERR = 2'h2;

   // per-cycle flag pulses
   typedef struct packed {
      logic idle_flag_a;
      logic idle_flag_b;
      logic jump_flag;
      logic return_flag;
   } obcu_flags_t;

   // data line outputs
   typedef struct packed {
      logic data_o;
      logic data_oe;
      logic write_strobe;
   } obcu_dout_t;

   // architectural state, as seen by software
   typedef struct packed {
      logic skip;
      logic out_en;
      logic in_en;
      logic result;
   } obcu_state_t;

endpackage : obcu_pkg

//--- verilog/obcu_axil_regs.sv
/*
 obcu_axil_regs: AXI4-Lite slave with status, control and instruction
 count words. assumes aclk domain inputs; one write and one read at once.
*/
`timescale 1ns/1ns
module obcu_axil_regs (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire obcu_pkg::obcu_state_t state,
   input wire logic [31:0] exec_count,
   output logic run
);

   logic aw_q, aw_d;
   logic w_q, w_d;
   logic [3:0] awaddr_q;
   logic wbit_q;
   logic wstrb0_q;
   logic run_q;
   logic bvalid_q;
   logic [1:0] bresp_q;
   logic rvalid_q;
   logic [31:0] rdata_q;
   logic [1:0] rresp_q;

   wire aw_take = s_axi_awvalid && !aw_q && !bvalid_q;
   wire w_take = s_axi_wvalid && !w_q && !bvalid_q;
   assign aw_d = aw_q | aw_take;
   assign w_d = w_q | w_take;
   wire [3:0] waddr = aw_take ? s_axi_awaddr : awaddr_q;
   wire wb = w_take ? s_axi_wdata[obcu_pkg::OBCU_CTRL_RUN] : wbit_q;
   wire ws = w_take ? s_axi_wstrb[0] : wstrb0_q;
   wire do_write = aw_d && w_d && !bvalid_q;
   wire wr_ctrl = waddr == obcu_pkg::OBCU_REG_CTRL;
   wire wr_ok = wr_ctrl || waddr == obcu_pkg::OBCU_REG_STATUS ||
      waddr == obcu_pkg::OBCU_REG_COUNT;

   wire ar_take = s_axi_arvalid && !rvalid_q;
   wire [31:0] rd_mux =
      (s_axi_araddr == obcu_pkg::OBCU_REG_STATUS) ? {28'h0, state} :
      (s_axi_araddr == obcu_pkg::OBCU_REG_CTRL) ? {31'h0, run_q} :
      (s_axi_araddr == obcu_pkg::OBCU_REG_COUNT) ? exec_count : 32'h0;
   wire rd_ok = s_axi_araddr == obcu_pkg::OBCU_REG_STATUS ||
      s_axi_araddr == obcu_pkg::OBCU_REG_CTRL ||
      s_axi_araddr == obcu_pkg::OBCU_REG_COUNT;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_q <= 1'b0;
         w_q <= 1'b0;
         awaddr_q <= 4'h0;
         wbit_q <= 1'b0;
         wstrb0_q <= 1'b0;
         run_q <= obcu_pkg::OBCU_RUN_RST;
         bvalid_q <= 1'b0;
         bresp_q <= obcu_pkg::OBCU_RESP_OKAY;
         rvalid_q <= 1'b0;
         rdata_q <= 32'h0;
         rresp_q <= obcu_pkg::OBCU_RESP_OKAY;
      end else begin
         aw_q <= do_write ? 1'b0 : aw_d;
         w_q <= do_write ? 1'b0 : w_d;
         if (aw_take) awaddr_q <= s_axi_awaddr;
         if (w_take) begin
            wbit_q <= s_axi_wdata[obcu_pkg::OBCU_CTRL_RUN];
            wstrb0_q <= s_axi_wstrb[0];
         end
         if (do_write && wr_ctrl && ws) run_q <= wb;
         if (do_write) begin
            bvalid_q <= 1'b1;
            bresp_q <= wr_ok ? obcu_pkg::OBCU_RESP_OKAY :
               obcu_pkg::OBCU_RESP_SLVERR;
         end else if (s_axi_bready) begin
            bvalid_q <= 1'b0;
         end
         if (ar_take) begin
            rvalid_q <= 1'b1;
            rdata_q <= rd_mux;
            rresp_q <= rd_ok ? obcu_pkg::OBCU_RESP_OKAY :
               obcu_pkg::OBCU_RESP_SLVERR;
         end else if (s_axi_rready) begin
            rvalid_q <= 1'b0;
         end
      end
   end

   assign s_axi_awready = !aw_q && !bvalid_q;
   assign s_axi_wready = !w_q && !bvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign run = run_q;

endmodule : obcu_axil_regs

//--- verilog/obcu_core.sv
/*
 obcu_core: instruction decode and one-bit logic core with an AXI4-Lite
 status slave. assumes opcode and data pins come from outside the aclk
 domain and are synchronised here; sequencing logic is external.
*/
`timescale 1ns/1ns
module obcu_core (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] opcode_in,
   input wire logic data_i,
   output logic data_o,
   output logic data_oe,
   output logic write_strobe,
   output logic result_register,
   output logic idle_flag_a,
   output logic idle_flag_b,
   output logic jump_flag,
   output logic return_flag,
   output logic oscillator_clock_out,
   input wire logic [3:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [3:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready
);

   // two-stage synchronisers for the pins
   logic [3:0] op_s1_q, op_s2_q;
   logic din_s1_q, din_s2_q;

   logic result_q, result_d;
   logic in_en_q, in_en_d;
   logic out_en_q, out_en_d;
   logic skip_q, skip_d;
   obcu_pkg::obcu_flags_t flags_q, flags_d;
   obcu_pkg::obcu_dout_t dout_q, dout_d;
   logic clk_out_q;
   logic [31:0] count_q;
   logic run;
   obcu_pkg::obcu_op_t op;

   // the logic unit is shared by all logic opcodes
   function automatic logic obcu_alu(input obcu_pkg::obcu_op_t o,
                                     input logic r, input logic d);
      logic v;
      v = r;
      case (o)
         obcu_pkg::OP_LOAD: v = d;
         obcu_pkg::OP_LOAD_INV: v = !d;
         obcu_pkg::OP_AND: v = r & d;
         obcu_pkg::OP_AND_INV: v = r & !d;
         obcu_pkg::OP_OR: v = r | d;
         obcu_pkg::OP_OR_INV: v = r | !d;
         obcu_pkg::OP_XNOR: v = (r == d);
         default: v = r;
      endcase
      return v;
   endfunction : obcu_alu

   // bit 3 is the opcode MSB
   assign op = obcu_pkg::obcu_op_t'(op_s2_q);

   // a skipped or halted slot executes nothing, but the data_o register still loads
   wire exec = run && !skip_q;

   wire din = din_s2_q & in_en_q;

   wire is_logic = op inside {obcu_pkg::OP_LOAD, obcu_pkg::OP_LOAD_INV,
      obcu_pkg::OP_AND, obcu_pkg::OP_AND_INV, obcu_pkg::OP_OR,
      obcu_pkg::OP_OR_INV, obcu_pkg::OP_XNOR};
   wire is_store = op == obcu_pkg::OP_WRITE ||
      op == obcu_pkg::OP_WRITE_INV;

   assign result_d = (exec && is_logic) ?
      obcu_alu(op, result_q, din) : result_q;

   assign in_en_d = (exec && op == obcu_pkg::OP_IN_EN) ?
      din_s2_q : in_en_q;
   assign out_en_d = (exec && op == obcu_pkg::OP_OUT_EN) ?
      din_s2_q : out_en_q;

   assign skip_d = exec && (op == obcu_pkg::OP_RETURN ||
      (op == obcu_pkg::OP_SKIP_ZERO && !result_q));

   assign flags_d.idle_flag_a = exec && op == obcu_pkg::OP_IDLE_A;
   assign flags_d.idle_flag_b = exec && op == obcu_pkg::OP_IDLE_B;
   assign flags_d.jump_flag = exec && op == obcu_pkg::OP_JUMP;
   assign flags_d.return_flag = exec && op == obcu_pkg::OP_RETURN;

   assign dout_d.data_o = (op == obcu_pkg::OP_WRITE_INV) ?
      !result_q : result_q;
   assign dout_d.data_oe = exec && is_store && out_en_q;
   assign dout_d.write_strobe = exec && is_store && out_en_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         op_s1_q <= 4'h0;
         op_s2_q <= 4'h0;
         din_s1_q <= 1'b0;
         din_s2_q <= 1'b0;
      end else begin
         op_s1_q <= opcode_in;
         op_s2_q <= op_s1_q;
         din_s1_q <= data_i;
         din_s2_q <= din_s1_q;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         result_q <= obcu_pkg::OBCU_RESULT_RST;
         in_en_q <= obcu_pkg::OBCU_IN_EN_RST;
         out_en_q <= obcu_pkg::OBCU_OUT_EN_RST;
         skip_q <= 1'b0;
         flags_q <= '0;
         dout_q <= '0;
      end else begin
         result_q <= result_d;
         in_en_q <= in_en_d;
         out_en_q <= out_en_d;
         skip_q <= skip_d;
         flags_q <= flags_d;
         dout_q <= dout_d;
      end
   end

   // clock out held low in reset, within one cycle
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         clk_out_q <= 1'b0;
      end else begin
         clk_out_q <= !clk_out_q;
      end
   end

   // executed-instruction counter for software
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         count_q <= 32'h0;
      end else if (exec) begin
         count_q <= count_q + 32'h1;
      end
   end

   obcu_axil_regs u_regs (
      .aclk(aclk),
      .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr),
      .s_axi_awvalid(s_axi_awvalid),
      .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata),
      .s_axi_wstrb(s_axi_wstrb),
      .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready),
      .s_axi_bresp(s_axi_bresp),
      .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready),
      .s_axi_araddr(s_axi_araddr),
      .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready),
      .s_axi_rdata(s_axi_rdata),
      .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid),
      .s_axi_rready(s_axi_rready),
      .state({skip_q, out_en_q, in_en_q, result_q}),
      .exec_count(count_q),
      .run(run)
   );

   assign data_o = dout_q.data_o;
   assign data_oe = dout_q.data_oe;
   assign write_strobe = dout_q.write_strobe;
   assign result_register = result_q;
   assign idle_flag_a = flags_q.idle_flag_a;
   assign idle_flag_b = flags_q.idle_flag_b;
   assign jump_flag = flags_q.jump_flag;
   assign return_flag = flags_q.return_flag;
   assign oscillator_clock_out = clk_out_q;

endmodule : obcu_core

//--- test/obcu_core_monitor.sv
/*
 obcu_core_monitor: port-level properties of the one-bit core.
 assumes one aclk domain and a synchronous active-low aresetn.
*/
`timescale 1ns/1ns
module obcu_core_monitor (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [3:0] opcode_in,
   input wire logic data_o,
   input wire logic write_strobe,
   input wire logic result_register,
   input wire logic idle_flag_a,
   input wire logic idle_flag_b,
   input wire logic jump_flag,
   input wire logic return_flag,
   input wire logic oscillator_clock_out
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);
   wire logic any_act = idle_flag_a | idle_flag_b | jump_flag | return_flag
      | write_strobe;

   // the synchroniser reads zero right after reset, hence the guard
   property p_idle_a;
      idle_flag_a && $past(aresetn, 3) |-> $past(opcode_in, 3) == 4'h0;
   endproperty
   a_idle_a: assert property (p_idle_a) else $error("idle a bad");
   property p_idle_b;
      idle_flag_b |-> $past(opcode_in, 3) == 4'hf;
   endproperty
   a_idle_b: assert property (p_idle_b) else $error("idle b bad");
   property p_jump;
      jump_flag |-> $past(opcode_in, 3) == 4'hc;
   endproperty
   a_jump: assert property (p_jump) else $error("jump bad");
   property p_ret;
      return_flag |-> ($past(opcode_in, 3) == 4'hd) ##1 !any_act;
   endproperty
   a_ret: assert property (p_ret) else $error("return bad");
   property p_store;
      write_strobe && $past(opcode_in, 3) == 4'h8
         |-> data_o == $past(result_register);
   endproperty
   a_store: assert property (p_store) else $error("store bad");
   property p_store_inv;
      write_strobe && $past(opcode_in, 3) == 4'h9
         |-> data_o == !$past(result_register);
   endproperty
   a_store_inv: assert property (p_store_inv) else $error("inv bad");
   property p_hold;
      jump_flag || return_flag |-> $stable(result_register);
   endproperty
   a_hold: assert property (p_hold) else $error("result moved");
   property p_rst_clk;
      $rose(aresetn) |-> !oscillator_clock_out;
   endproperty
   a_rst_clk: assert property (p_rst_clk) else $error("clock out");
endmodule : obcu_core_monitor

bind obcu_core obcu_core_monitor mon (.aclk, .aresetn, .opcode_in, .data_o,
   .write_strobe, .result_register, .idle_flag_a, .idle_flag_b, .jump_flag,
   .return_flag, .oscillator_clock_out);

//--- test/obcu_line_model.sv
/*
 obcu_line_model: far side of the data line, an output latch and an
 input source. assumes the core drives the line only while data_oe.
*/
`timescale 1ns/1ns
module obcu_line_model (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic data_o,
   input wire logic data_oe,
   input wire logic write_strobe,
   input wire logic drive_bit,
   output logic data_i,
   output logic latch_q
);
   // one wire: the core wins while enabled, else the selected input
   assign data_i = data_oe ? data_o : drive_bit;
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         latch_q <= 1'b0;
      end else if (write_strobe) begin
         latch_q <= data_o;
      end
   end
endmodule : obcu_line_model

//--- test/testbench.sv
/*
 testbench: directed and random opcode streams against a cycle model,
 plus register accesses. assumes a 100 MHz aclk and synchronous reset.
*/
`timescale 1ns/1ns
module testbench;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [3:0] opcode_in = 4'h0;
   logic drive_bit = 1'b0;
   logic data_i, data_o, data_oe, write_strobe, result_register, latch_q;
   logic idle_flag_a, idle_flag_b, jump_flag, return_flag;
   logic oscillator_clock_out;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, q;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   logic s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp, r;
   logic chk_en = 1'b0;
   logic m_run = 1'b1;
   logic [4:0] m1, m2;
   logic e_res, e_ien, e_oen, e_skip, e_ia, e_ib, e_j, e_r, e_ws, e_oe;
   logic e_do, e_osc, e_lat;
   int n_mismatch = 0;
   int n_compared = 0;
   // {opcode, data bit} corner program
   logic [4:0] prog [21] = '{5'h15, 5'h17, 5'h03, 5'h10, 5'h12, 5'h1c,
      5'h06, 5'h1c, 5'h18, 5'h1a, 5'h1e, 5'h00, 5'h0e, 5'h0e, 5'h0c, 5'h09,
      5'h0b, 5'h14, 5'h05, 5'h16, 5'h10};

   obcu_core DUT (
      .aclk, .aresetn, .opcode_in, .data_i, .data_o, .data_oe,
      .write_strobe, .result_register, .idle_flag_a, .idle_flag_b,
      .jump_flag, .return_flag, .oscillator_clock_out,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
      .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
      .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
      .s_axi_rready
   );
   obcu_line_model far_end (.aclk, .aresetn, .data_o, .data_oe,
      .write_strobe, .drive_bit, .data_i, .latch_q);

   initial begin
      forever #5 aclk = ~aclk;
   end

   function automatic logic exp_res(input logic [3:0] op, input logic rv,
                                    input logic d);
      case (op)
         4'h1: return d;
         4'h2: return !d;
         4'h3: return rv & d;
         4'h4: return rv & !d;
         4'h5: return rv | d;
         4'h6: return rv | !d;
         4'h7: return rv == d;
         default: return rv;
      endcase
   endfunction : exp_res

   // two-stage pin sync, then execution one edge later
   always @(posedge aclk) begin
      e_osc <= aresetn & !e_osc;
      {e_ia, e_ib, e_j, e_r, e_ws, e_oe} <= 6'h0;
      e_lat <= aresetn & (e_ws ? e_do : e_lat);
      if (!aresetn) begin
         {m1, m2} <= 10'h0;
         {e_res, e_ien, e_oen, e_skip} <= 4'h0;
      end else begin
         m1 <= {opcode_in, data_i};
         m2 <= m1;
         // a skipped slot clears the pending skip even while halted
         if (e_skip) begin
            e_skip <= 1'b0;
         end else if (m_run) begin
            e_res <= exp_res(m2[4:1], e_res, e_ien & m2[0]);
            case (m2[4:1])
               4'h0: e_ia <= 1'b1;
               4'h8, 4'h9: begin
                  e_ws <= e_oen;
                  e_oe <= e_oen;
                  e_do <= e_res ^ m2[1];
               end
               4'ha: e_ien <= m2[0];
               4'hb: e_oen <= m2[0];
               4'hc: e_j <= 1'b1;
               4'hd: {e_r, e_skip} <= 2'h3;
               4'he: e_skip <= !e_res;
               4'hf: e_ib <= 1'b1;
               default: ;
            endcase
         end
      end
   end

   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask : check

   always @(negedge aclk) begin
      if (chk_en) begin
         check(32'(result_register), 32'(e_res));
         check(32'({idle_flag_a, idle_flag_b}), 32'({e_ia, e_ib}));
         check(32'({jump_flag, return_flag}), 32'({e_j, e_r}));
         check(32'({write_strobe, data_oe}), 32'({e_ws, e_oe}));
         check(32'(latch_q), 32'(e_lat));
         check(32'(oscillator_clock_out), 32'(e_osc));
         if (e_oe) check(32'(data_o), 32'(e_do));
      end
   end

   task automatic stop_test();
      $display("mismatches %0d compared %0d", n_mismatch, n_compared);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : stop_test

   // one transfer; ready is judged at the negedge before the taking edge
   task automatic axi(input bit wr, input logic [3:0] a,
                      input logic [31:0] d);
      int n;
      logic aw, w, ar, fin;
      n = 0;
      fin = 1'b0;
      @(posedge aclk);
      if (wr) begin
         s_axi_awaddr <= a;
         s_axi_wdata <= d;
         s_axi_awvalid <= 1'b1;
         s_axi_wvalid <= 1'b1;
         s_axi_bready <= 1'b1;
      end else begin
         s_axi_araddr <= a;
         s_axi_arvalid <= 1'b1;
         s_axi_rready <= 1'b1;
      end
      while (!fin) begin
         @(negedge aclk);
         aw = s_axi_awvalid & s_axi_awready;
         w = s_axi_wvalid & s_axi_wready;
         ar = s_axi_arvalid & s_axi_arready;
         fin = wr ? s_axi_bvalid : s_axi_rvalid;
         r = wr ? s_axi_bresp : s_axi_rresp;
         q = s_axi_rdata;
         @(posedge aclk);
         if (aw) s_axi_awvalid <= 1'b0;
         if (w) s_axi_wvalid <= 1'b0;
         if (ar) s_axi_arvalid <= 1'b0;
         if (fin) begin
            s_axi_bready <= 1'b0;
            s_axi_rready <= 1'b0;
         end
         n++;
         if (n > 50) begin
            n_mismatch++;
            stop_test();
         end
      end
   endtask : axi

   task automatic reg_chk(input bit wr, input logic [3:0] a,
                          input logic [31:0] d, input logic [1:0] er);
      axi(wr, a, d);
      check(32'(r), 32'(er));
      if (!wr) check(q, d);
   endtask : reg_chk

   task automatic ops(input int n, input bit rnd);
      repeat (n) begin
         @(posedge aclk);
         opcode_in <= rnd ? 4'($urandom_range(15, 0)) : 4'h0;
         drive_bit <= rnd ? 1'($urandom_range(1, 0)) : 1'b0;
      end
   endtask : ops

   initial begin
      void'($urandom(22750));
      repeat (4) @(posedge aclk);
      aresetn <= 1'b1;
      chk_en <= 1'b1;
      ops(4, 0);
      reg_chk(0, obcu_pkg::OBCU_REG_CTRL, 32'h1, obcu_pkg::OBCU_RESP_OKAY);
      reg_chk(0, 4'hc, 32'h0, obcu_pkg::OBCU_RESP_SLVERR);
      reg_chk(1, obcu_pkg::OBCU_REG_STATUS, 32'hf, obcu_pkg::OBCU_RESP_OKAY);
      foreach (prog[i]) begin
         @(posedge aclk);
         opcode_in <= prog[i][4:1];
         drive_bit <= prog[i][0];
      end
      ops(6, 0);
      reg_chk(0, obcu_pkg::OBCU_REG_STATUS,
              32'({e_skip, e_oen, e_ien, e_res}), 2'h0);
      ops(400, 1);
      ops(6, 0);
      reg_chk(0, obcu_pkg::OBCU_REG_STATUS,
              32'({e_skip, e_oen, e_ien, e_res}), 2'h0);
      // halted core must ignore a random stream
      chk_en <= 1'b0;
      axi(1, obcu_pkg::OBCU_REG_CTRL, 32'h0);
      m_run <= 1'b0;
      ops(6, 0);
      chk_en <= 1'b1;
      ops(30, 1);
      ops(6, 0);
      chk_en <= 1'b0;
      axi(1, obcu_pkg::OBCU_REG_CTRL, 32'h1);
      m_run <= 1'b1;
      ops(6, 0);
      chk_en <= 1'b1;
      ops(50, 1);
      aresetn <= 1'b0;
      ops(2, 1);
      aresetn <= 1'b1;
      ops(100, 1);
      stop_test();
   end
endmodule : testbench
